// ==== src/wdt_top.sv ====
`timescale 1ns/100ps
`include "wdt_consts.svh"
// Operation
// - AAh then 55h to key opens window
// - protected write outside window is dropped
// - reset enable and restart need unlock
// - free count to timeout sets flag
// - two select bits pick four timeouts
// - timeout sets reset flag, resets if enabled
// - interrupt flag 512 clocks before reset flag
// - interrupt enable independent of reset enable
// - divider bits scale timeout, multiplier only with divider code 00
// - timeout table by divider code, plus 512
// - interrupt also drives wake request
module wdt_top #(
  parameter logic [5:0] TIMEOUT_SHRINK = 6'h00
) (
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic [7:0] sfr_addr,
  input  wire logic       sfr_wr,
  input  wire logic [7:0] sfr_wdata,
  input  wire logic       sfr_rd,
  input  wire logic       timeout_sel_hi,
  input  wire logic       timeout_sel_lo,
  input  wire logic       clk_div_hi,
  input  wire logic       clk_div_lo,
  input  wire logic       clk_multiplier_sel,
  input  wire logic       wdog_irq_enable,
  output logic [7:0]      sfr_rdata,
  output logic            wdog_irq,
  output logic            wdog_wake,
  output logic            wdog_cpu_reset,
  output logic            wdog_irq_flag,
  output logic            wdog_reset_flag,
  output logic            wdog_reset_enable
);
  // ----------------------------------------
  // declarations
  // ----------------------------------------
  wdt_pkg::wdt_state_t s;       // current state
  wdt_pkg::wdt_state_t next_s;  // next state
  logic        ta_open;         // unlock window open
  logic        ctrl_wr;         // control register write
  logic        prot_ok;         // unlocked control write
  logic        restart;         // unlocked restart request
  logic [5:0]  base_exp;        // exponent for select 00
  logic [5:0]  sel3;            // three times select
  logic [5:0]  irq_exp;         // interrupt exponent
  logic [34:0] irq_limit;       // interrupt timeout count
  logic [34:0] rst_point;       // last count before reset

  assign ctrl_wr = sfr_wr && (sfr_addr == `WDT_CTRL_ADDR);
  assign prot_ok = ctrl_wr && ta_open;
  assign restart = prot_ok && sfr_wdata[`WDT_BIT_RESTART];

  // ----------------------------------------
  // unlock sequencer
  // ----------------------------------------
  wdt_timed_access u_ta (
    .clk       (clk),
    .reset_n   (reset_n),
    .sfr_addr  (sfr_addr),
    .sfr_wr    (sfr_wr),
    .sfr_wdata (sfr_wdata),
    .consume   (ctrl_wr),
    .ta_open   (ta_open)
  );

  // ----------------------------------------
  // timeout selection
  // ----------------------------------------
  // base exponent from divider and multiplier
  always_comb
  begin
    case ({clk_div_hi, clk_div_lo})
      2'b00:   base_exp = clk_multiplier_sel ? `WDT_EXP_DIV0_X4 : `WDT_EXP_DIV0_X2;
      2'b11:   base_exp = `WDT_EXP_PMM;
      default: base_exp = `WDT_EXP_STD;
    endcase
  end

  // select adds three octaves per step
  assign sel3      = {3'h0, timeout_sel_hi, timeout_sel_lo, 1'b0}
                   + {4'h0, timeout_sel_hi, timeout_sel_lo};
  assign irq_exp   = base_exp + sel3 - TIMEOUT_SHRINK;
  assign irq_limit = 35'h1 << irq_exp;
  assign rst_point = irq_limit + `WDT_RST_GAP - 35'h1;

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb
  begin
    next_s           = s;
    next_s.cpu_reset = 1'b0;
    // software writes first, hardware sets override
    if (prot_ok)
    begin
      next_s.rst_en   = sfr_wdata[`WDT_BIT_RST_EN];
      next_s.irq_flag = sfr_wdata[`WDT_BIT_IRQ_FLAG];
    end
    // reset flag cleared by writing zero
    if (ctrl_wr && !sfr_wdata[`WDT_BIT_RST_FLAG])
      next_s.rst_flag = 1'b0;
    // counter
    if (restart)
      next_s.cnt = 35'h0;
    else if (s.cnt >= rst_point)
    begin
      // reset timeout: flag, optional reset, wrap
      next_s.cnt       = 35'h0;
      next_s.rst_flag  = 1'b1;
      next_s.cpu_reset = s.rst_en;
    end
    else
    begin
      next_s.cnt = s.cnt + 35'h1;
      if (s.cnt == irq_limit - 35'h1)
        next_s.irq_flag = 1'b1;
    end
    // interrupt gated only by its own enable
    next_s.irq_out  = s.irq_flag && wdog_irq_enable;
    next_s.wake_out = s.irq_flag && wdog_irq_enable;
    // read data, key reads as zero
    if (sfr_rd && sfr_addr == `WDT_CTRL_ADDR)
      next_s.rdata = {4'h0, s.irq_flag, s.rst_flag, s.rst_en, 1'b0};
    else
      next_s.rdata = 8'h00;
  end

  // state register
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      s <= '0;
    else
      s <= next_s;
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign sfr_rdata         = s.rdata;
  assign wdog_irq          = s.irq_out;
  assign wdog_wake         = s.wake_out;
  assign wdog_cpu_reset    = s.cpu_reset;
  assign wdog_irq_flag     = s.irq_flag;
  assign wdog_reset_flag   = s.rst_flag;
  assign wdog_reset_enable = s.rst_en;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence s_locked_wr;
    ctrl_wr && !ta_open;
  endsequence

  sequence s_irq_point;
    !restart && s.cnt == irq_limit - 35'h1;
  endsequence

  sequence s_rst_point;
    !restart && s.cnt >= rst_point;
  endsequence

  a_locked_enable: assert property (s_locked_wr |=> $stable(s.rst_en))
    else $error("locked write changed reset enable");
  a_locked_restart: assert property (
    s_locked_wr ##0 (s.cnt < 35'h10 && s.cnt < rst_point) |=> s.cnt != 35'h0)
    else $error("locked write restarted counter");
  a_restart_zero: assert property (restart |=> s.cnt == 35'h0)
    else $error("unlocked restart did not clear counter");
  a_irq_at_limit: assert property (s_irq_point |=> s.irq_flag)
    else $error("interrupt flag missing at timeout");
  a_rst_gap: assert property (
    s_rst_point |-> rst_point - irq_limit == 35'h1ff ##1 s.rst_flag && s.cnt == 35'h0)
    else $error("reset flag not 512 clocks after interrupt");
  a_rst_gated: assert property (
    s_rst_point |=> s.cpu_reset == $past(s.rst_en))
    else $error("cpu reset not gated by enable");
  a_no_stray_rst: assert property (s.cpu_reset |-> $past(s.rst_en))
    else $error("cpu reset without enable");
  a_pmm_exp: assert property (
    {clk_div_hi, clk_div_lo} == 2'b11 |-> irq_exp == 6'h19 + sel3 - TIMEOUT_SHRINK)
    else $error("wrong timeout for slowest divider");
  a_irq_gate: assert property (
    (s.irq_flag && wdog_irq_enable) [*2] |-> wdog_irq && wdog_wake)
    else $error("enabled interrupt not raised");

  // ----------------------------------------
  // counter and flag checks
  // ----------------------------------------
  // counter steps by one away from events
  a_count_step: assert property (
    !restart && s.cnt < rst_point |=> s.cnt == $past(s.cnt) + 35'h1)
    else $error("watchdog counter did not advance");

  // reset pulse lasts a single clock
  a_pulse_once: assert property (s.cpu_reset |=> !s.cpu_reset)
    else $error("cpu reset pulse too long");

  // reset enable moves only through the window
  a_enable_guard: assert property ($changed(s.rst_en) |-> $past(prot_ok))
    else $error("reset enable changed while locked");

  // reset flag rises only at the reset point
  a_rst_rise: assert property (
    $rose(s.rst_flag) |-> $past(s.cnt) >= $past(rst_point))
    else $error("reset flag set early");

  // interrupt flag rises at the limit or by unlocked write
  a_irq_rise: assert property (
    $rose(s.irq_flag) |-> $past(prot_ok) || $past(s.cnt) == $past(irq_limit) - 35'h1)
    else $error("interrupt flag set early");

  // disabled interrupt stays quiet
  a_irq_off: assert property (
    !wdog_irq_enable |=> !wdog_irq && !wdog_wake)
    else $error("disabled interrupt raised");
endmodule // wdt_top

// ==== pkg/wdt_consts.svh ====
`ifndef WDT_CONSTS_SVH
`define WDT_CONSTS_SVH
// ----------------------------------------
// register addresses and key values
// ----------------------------------------
`define WDT_KEY_ADDR     8'hc7
`define WDT_KEY_FIRST    8'haa
`define WDT_KEY_SECOND   8'h55
`define WDT_CTRL_ADDR    8'hd8
`define WDT_CTRL_RESET   8'h00
// ----------------------------------------
// watchdog control field positions
// ----------------------------------------
`define WDT_BIT_RESTART  0
`define WDT_BIT_RST_EN   1
`define WDT_BIT_RST_FLAG 2
`define WDT_BIT_IRQ_FLAG 3
// ----------------------------------------
// timing
// ----------------------------------------
`define WDT_TA_WINDOW    2'h3
`define WDT_RST_GAP      35'h0000_0200
`define WDT_EXP_DIV0_X4  6'h0f
`define WDT_EXP_DIV0_X2  6'h10
`define WDT_EXP_STD      6'h11
`define WDT_EXP_PMM      6'h19
`endif

// ==== pkg/wdt_pkg.sv ====
// ----------------------------------------
// shared types
// ----------------------------------------
package wdt_pkg;
  // unlock sequencer states
  typedef enum logic [1:0] {
    TA_IDLE  = 2'b00,
    TA_FIRST = 2'b01,
    TA_OPEN  = 2'b10
  } wdt_ta_st_t;

  // unlock sequencer state
  typedef struct packed {
    wdt_ta_st_t st;    // sequence position
    logic [1:0] left;  // open cycles left
  } wdt_ta_t;

  // watchdog state
  typedef struct packed {
    logic [34:0] cnt;        // clock counter
    logic        irq_flag;   // interrupt flag
    logic        rst_flag;   // timeout-reset flag
    logic        rst_en;     // reset enable
    logic [7:0]  rdata;      // read data
    logic        irq_out;    // gated interrupt
    logic        wake_out;   // wake request
    logic        cpu_reset;  // reset pulse
  } wdt_state_t;
endpackage

// ==== src/wdt_timed_access.sv ====
`timescale 1ns/100ps
`include "wdt_consts.svh"
module wdt_timed_access (
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic [7:0] sfr_addr,
  input  wire logic       sfr_wr,
  input  wire logic [7:0] sfr_wdata,
  input  wire logic       consume,
  output logic            ta_open
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  wdt_pkg::wdt_ta_t s;       // current state
  wdt_pkg::wdt_ta_t next_s;  // next state
  logic key_wr;              // write to key register

  assign key_wr  = sfr_wr && (sfr_addr == `WDT_KEY_ADDR);
  assign ta_open = (s.st == wdt_pkg::TA_OPEN);

  // sequence tracking and window timer
  always_comb
  begin
    next_s = s;
    case (s.st)
      wdt_pkg::TA_IDLE:
      begin
        if (key_wr && sfr_wdata == `WDT_KEY_FIRST)
          next_s.st = wdt_pkg::TA_FIRST;
      end
      wdt_pkg::TA_FIRST:
      begin
        // any write other than either key byte breaks the sequence; a repeated first key holds it
        if (key_wr && sfr_wdata == `WDT_KEY_SECOND)
        begin
          next_s.st   = wdt_pkg::TA_OPEN;
          next_s.left = `WDT_TA_WINDOW;
        end
        else if (key_wr && sfr_wdata == `WDT_KEY_FIRST)
          next_s.st = wdt_pkg::TA_FIRST;
        else if (sfr_wr)
          next_s.st = wdt_pkg::TA_IDLE;
      end
      wdt_pkg::TA_OPEN:
      begin
        // one protected write or three cycles close it
        next_s.left = s.left - 2'h1;
        // a fresh first key restarts the sequence
        if (key_wr && sfr_wdata == `WDT_KEY_FIRST)
          next_s.st = wdt_pkg::TA_FIRST;
        else if (consume || s.left == 2'h1)
          next_s.st = wdt_pkg::TA_IDLE;
      end
      default:
        next_s.st = wdt_pkg::TA_IDLE;
    endcase
  end

  // state register
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      s <= '{st: wdt_pkg::TA_IDLE, left: 2'h0};
    else
      s <= next_s;
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence s_key;
    (key_wr && sfr_wdata == `WDT_KEY_FIRST) ##1 (key_wr && sfr_wdata == `WDT_KEY_SECOND);
  endsequence

  a_key_opens: assert property (s_key |=> ta_open)
    else $error("key sequence did not open window");
  a_window_len: assert property (s_key |=> ta_open ##3 !ta_open)
    else $error("window longer than three cycles");
endmodule // wdt_timed_access

// ==== test/tb_top.sv ====
`timescale 1ns/100ps
`include "wdt_consts.svh"
module tb_top;
  // ------------------------------
  // stimulus and observed signals
  // ------------------------------
  logic       clk = 1'b0;
  logic       reset_n = 1'b0;
  logic [7:0] sfr_addr = 8'h00;
  logic       sfr_wr = 1'b0;
  logic [7:0] sfr_wdata = 8'h00;
  logic       sfr_rd = 1'b0;
  logic [4:0] cfg = 5'h00;    // sel hi/lo, div hi/lo, multiplier
  logic       irq_en = 1'b0;
  logic [7:0] sfr_rdata;
  logic       wdog_irq, wdog_wake, wdog_cpu_reset;
  logic       wdog_irq_flag, wdog_reset_flag, wdog_reset_enable;
  logic [7:0] rd_val;         // last read result
  int         failures = 0;
  int         cmp_count = 0;

  // 50 MHz clock
  always #10 clk = ~clk;

  // shrink of 10 keeps the longest tested count near 2^15
  wdt_top #(.TIMEOUT_SHRINK(6'h0a)) i_wdt_top (
    .clk(clk), .reset_n(reset_n), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd), .timeout_sel_hi(cfg[4]),
    .timeout_sel_lo(cfg[3]), .clk_div_hi(cfg[2]), .clk_div_lo(cfg[1]),
    .clk_multiplier_sel(cfg[0]), .wdog_irq_enable(irq_en),
    .sfr_rdata(sfr_rdata), .wdog_irq(wdog_irq), .wdog_wake(wdog_wake),
    .wdog_cpu_reset(wdog_cpu_reset), .wdog_irq_flag(wdog_irq_flag),
    .wdog_reset_flag(wdog_reset_flag), .wdog_reset_enable(wdog_reset_enable)
  );

  // ------------------------------
  // shared tasks
  // ------------------------------
  // compare and count
  task automatic check(input logic [35:0] seen, input logic [35:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      failures++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // verdict and end of run
  task automatic finish_test;
    if (failures == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // register write sampled gap+1 edges after entry
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input int gap);
    repeat (gap) @(posedge clk);
    sfr_addr  <= a;
    sfr_wdata <= d;
    sfr_wr    <= 1'b1;
    @(posedge clk);
    sfr_wr <= 1'b0;
    #1;
  endtask

  // register read, data taken the cycle after the strobe edge
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    sfr_addr <= a;
    sfr_rd   <= 1'b1;
    @(posedge clk);
    sfr_rd <= 1'b0;
    #1 rd_val = sfr_rdata;
  endtask

  // two-step key
  task automatic unlock;
    wr(`WDT_KEY_ADDR, `WDT_KEY_FIRST, 1);
    wr(`WDT_KEY_ADDR, `WDT_KEY_SECOND, 1);
  endtask

  // ------------------------------
  // scenarios
  // ------------------------------
  // idle state after reset
  task automatic t_reset;
    check({wdog_irq, wdog_cpu_reset, wdog_irq_flag, wdog_reset_flag}, 0);
    rd(`WDT_CTRL_ADDR);
    check(rd_val, `WDT_CTRL_RESET);
    rd(`WDT_KEY_ADDR);
    check(rd_val, 8'h00);
  endtask

  // protected enable bit against bad sequences
  task automatic t_protect;
    wr(`WDT_CTRL_ADDR, 8'h02, 1);
    check(wdog_reset_enable, 1'b0);
    wr(`WDT_KEY_ADDR, `WDT_KEY_FIRST, 1);
    wr(8'h80, 8'h00, 1);
    wr(`WDT_KEY_ADDR, `WDT_KEY_SECOND, 1);
    wr(`WDT_CTRL_ADDR, 8'h02, 1);
    check(wdog_reset_enable, 1'b0);
    unlock();
    wr(`WDT_CTRL_ADDR, 8'h02, 3);
    check(wdog_reset_enable, 1'b0);
    unlock();
    wr(`WDT_CTRL_ADDR, 8'h02, 2);
    check(wdog_reset_enable, 1'b1);
    wr(`WDT_CTRL_ADDR, 8'h00, 1);
    check(wdog_reset_enable, 1'b1);
    rd(`WDT_CTRL_ADDR);
    check(rd_val, 8'h02);
    unlock();
    wr(`WDT_CTRL_ADDR, 8'h00, 1);
    check(wdog_reset_enable, 1'b0);
  endtask

  // restart, then time interrupt and reset flags
  task automatic t_run(input logic [4:0] c, input int e, input logic en, input logic ie);
    int n;
    @(posedge clk);
    cfg    <= c;
    irq_en <= ie;
    unlock();
    wr(`WDT_CTRL_ADDR, {6'h00, en, 1'b1}, 1);
    check({wdog_irq_flag, wdog_reset_flag}, 0);
    n = 0;
    while (wdog_irq_flag !== 1'b1 && n < 40000)
    begin
      @(posedge clk);
      #1 n++;
    end
    check(n, 1 << e);
    repeat (2) @(posedge clk);
    #1 check({wdog_irq, wdog_wake}, {ie, ie});
    n = 2;
    while (wdog_reset_flag !== 1'b1 && n < 1000)
    begin
      @(posedge clk);
      #1 n++;
    end
    check(n, 512);
    check({wdog_cpu_reset, wdog_irq_flag}, {en, 1'b1});
    @(posedge clk);
    #1 check(wdog_cpu_reset, 1'b0);
  endtask

  // flag clearing rules
  task automatic t_clear;
    wr(`WDT_CTRL_ADDR, 8'h00, 1);
    check({wdog_irq_flag, wdog_reset_flag}, 2'b10);
    rd(`WDT_CTRL_ADDR);
    check(rd_val, 8'h08);
  endtask

  // periodic restart holds off the reset, neglect lets it fire
  task automatic t_kick;
    @(posedge clk);
    cfg <= 5'b00001;
    repeat (4)
    begin
      repeat (300) @(posedge clk);
      unlock();
      wr(`WDT_CTRL_ADDR, 8'h03, 1);
    end
    check({wdog_reset_flag, wdog_cpu_reset}, 0);
    repeat (560) @(posedge clk);
    #1 check(wdog_reset_flag, 1'b1);
  endtask

  // ------------------------------
  // main sequence and watchdog
  // ------------------------------
  initial
  begin
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    #1 t_reset();
    t_protect();
    t_run(5'b00001, 5, 1'b1, 1'b0);
    t_run(5'b00000, 6, 1'b0, 1'b1);
    t_run(5'b00010, 7, 1'b1, 1'b1);
    t_run(5'b00100, 7, 1'b0, 1'b0);
    t_run(5'b01010, 10, 1'b1, 1'b0);
    t_run(5'b10001, 11, 1'b0, 1'b1);
    t_run(5'b11001, 14, 1'b1, 1'b1);
    t_run(5'b00110, 15, 1'b0, 1'b0);
    t_clear();
    t_kick();
    finish_test();
  end

  // hang guard, well past the expected run
  initial
  begin
    #1900000;
    failures++;
    finish_test();
  end
endmodule // tb_top
